//--- rtl/dba_device.sv
`timescale 1ns/1ps
`default_nettype none
module dba_device #(
   parameter int HBLANK_CHARS = `DBA_HBLANK_CHARS,
   parameter int VBLANK_ROWS  = `DBA_VBLANK_ROWS
) (
   input  wire logic          mclk,
   input  wire logic          rst,
   dba_link_if.device         link,
   output logic               bufferChipSelect,
   output logic               latchLoadStrobe,
   output logic               latchDriveStrobe,
   output dba_pkg::dba_addr_t ramAddr,
   output dba_pkg::dba_data_t ramDataOut,
   output logic               ramDataOe,
   input  wire dba_pkg::dba_data_t ramDataIn,
   output logic               hsync,
   output logic               vsync,
   output logic               compositeBlanking,
   output logic               cursorOut,
   output logic [3:0]         lineAddr,
   output logic               oddField
);
   import dba_pkg::*;

   dba_dev_t   st;
   dba_dev_t   nxt_st;
   logic [7:0] hCnt;
   logic [3:0] lineCnt;
   logic [4:0] rowCnt;
   logic       hWrap;
   logic       lWrap;
   logic       rWrap;
   logic [6:0] chars;
   logic [3:0] linesM1;
   logic [4:0] rows;
   logic [7:0] hLimit;
   logic [7:0] hHalf;
   logic       hAct;
   logic       activeRow;
   logic       inWindow;
   logic       vStart;
   logic       frameEnd;
   logic       vsyncEven;
   logic       vsyncOdd;
   logic       blinkOn;
   logic       cmdWr;
   logic       readyEvt;
   logic [1:0] clrBits;
   logic [1:0] op;
   dba_addr_t  dispAddr;

   assign chars   = st.format[6:0];
   assign linesM1 = st.format[10:7];
   assign rows    = st.format[15:11];
   assign hLimit  = 8'(int'(chars) + HBLANK_CHARS - 1);
   assign hHalf   = hLimit >> 1;

   dba_span_counter #(.W(8)) u_hcnt (
      .mclk  (mclk),
      .rst   (rst),
      .step  (1'b1),
      .limit (hLimit),
      .count (hCnt),
      .wrap  (hWrap)
   );
   dba_span_counter #(.W(4)) u_lcnt (
      .mclk  (mclk),
      .rst   (rst),
      .step  (hWrap),
      .limit (linesM1),
      .count (lineCnt),
      .wrap  (lWrap)
   );
   dba_span_counter #(.W(5)) u_rcnt (
      .mclk  (mclk),
      .rst   (rst),
      .step  (hWrap & lWrap),
      .limit (5'(int'(rows) + VBLANK_ROWS - 1)),
      .count (rowCnt),
      .wrap  (rWrap)
   );

   always_comb begin
      nxt_st    = st;
      readyEvt  = 1'b0;
      op        = link.regWdata[1:0];
      hAct      = hCnt < {1'b0, chars};
      activeRow = rowCnt < rows;
      inWindow  = activeRow & ~st.control[`DBA_CTL_BLANK];
      vStart    = hWrap & lWrap & (rowCnt == rows - 5'h1);
      // Last cycle of the frame leaves no flyback for a two-cycle transfer
      frameEnd  = hWrap & lWrap & rWrap & ~st.control[`DBA_CTL_BLANK];
      dispAddr  = `DBA_AW'(rowCnt * chars) + `DBA_AW'(hCnt);
      blinkOn   = st.control[`DBA_CTL_BLINKFAST] ? st.frame[3] : st.frame[4];
      cmdWr     = link.regWr & (link.regAddr == `DBA_REG_COMMAND);
      clrBits   = (link.regWr & (link.regAddr == `DBA_REG_STATUS)) ?
                  link.regWdata[1:0] : 2'h0;

      // Raster outputs, registered one character late as a group
      nxt_st.dispAddr = dispAddr;
      nxt_st.lineAddr = st.control[`DBA_CTL_DOUBLEH] ?
                        {1'b0, lineCnt[3:1]} : lineCnt;
      nxt_st.hsync = (hCnt >= 8'(int'(chars) + `DBA_HSYNC_START)) &&
                     (hCnt < 8'(int'(chars) + `DBA_HSYNC_END));
      vsyncEven = (rowCnt == rows) && (lineCnt < 4'(`DBA_VSYNC_LINES));
      // Odd interlace field shifts vertical sync by half a line
      vsyncOdd  = (rowCnt == rows) &&
                  ((lineCnt != 4'h0) || (hCnt >= hHalf)) &&
                  ((lineCnt < 4'(`DBA_VSYNC_LINES)) ||
                   ((lineCnt == 4'(`DBA_VSYNC_LINES)) && (hCnt < hHalf)));
      nxt_st.vsync = (st.control[`DBA_CTL_INTERLACE] & st.field) ?
                     vsyncOdd : vsyncEven;
      nxt_st.blank = ~(hAct & activeRow) | st.control[`DBA_CTL_BLANK] |
                     st.fillBlank;
      nxt_st.cursorOut = hAct & activeRow & (dispAddr == st.cursor) & blinkOn &
                         (st.control[`DBA_CTL_BLOCKCUR] | (lineCnt == linesM1));
      if (hWrap & lWrap & rWrap) begin
         nxt_st.frame = st.frame + 6'h1;
         nxt_st.field = st.control[`DBA_CTL_INTERLACE] & ~st.field;
      end

      // Register port
      if (link.regWr) begin
         unique case (link.regAddr)
            `DBA_REG_CURSOR:  nxt_st.cursor  = link.regWdata[`DBA_AW-1:0];
            `DBA_REG_POINTER: nxt_st.pointer = link.regWdata[`DBA_AW-1:0];
            `DBA_REG_CONTROL: nxt_st.control = link.regWdata;
            `DBA_REG_FORMAT:  nxt_st.format  = link.regWdata;
            default: ;
         endcase
      end
      if (link.latchWr) begin
         nxt_st.latch = link.latchWdata;
      end
      if (vStart && st.seq != SEQ_FILL) begin
         nxt_st.fillBlank = 1'b0;
      end

      unique case (st.seq)
         SEQ_IDLE: begin
            // Commands are taken only while done is set and op is legal
            if (cmdWr && st.done && op != 2'h3) begin
               nxt_st.done      = 1'b0;
               nxt_st.phase     = 1'b0;
               nxt_st.doWrite   = link.regWdata[`DBA_CMD_WRITE] | (op == `DBA_OP_FILL);
               nxt_st.doIncr    = link.regWdata[`DBA_CMD_INCR];
               nxt_st.useCursor = (op != `DBA_OP_POINTER);
               nxt_st.work      = (op == `DBA_OP_POINTER) ? st.pointer : st.cursor;
               if (op == `DBA_OP_FILL) begin
                  nxt_st.seq       = SEQ_FILL;
                  nxt_st.fillBlank = 1'b1;
               end else if (inWindow || frameEnd) begin
                  nxt_st.seq = SEQ_WAIT;
               end else begin
                  nxt_st.seq = SEQ_XFER;
               end
            end
         end
         SEQ_WAIT: begin
            if (hCnt == {1'b0, chars} || !inWindow) begin
               nxt_st.seq = SEQ_XFER;
            end
         end
         SEQ_XFER: begin
            nxt_st.phase = ~st.phase;
            if (st.phase) begin
               if (!st.doWrite) begin
                  nxt_st.latch = ramDataIn;
               end
               if (st.useCursor && st.doIncr) begin
                  nxt_st.cursor = st.cursor + `DBA_AW'(1);
               end
               nxt_st.done = 1'b1;
               readyEvt    = 1'b1;
               nxt_st.seq  = SEQ_IDLE;
            end
         end
         SEQ_FILL: begin
            nxt_st.phase = ~st.phase;
            if (st.phase) begin
               if (st.work == st.pointer) begin
                  nxt_st.done = 1'b1;
                  readyEvt    = 1'b1;
                  nxt_st.seq  = SEQ_IDLE;
               end else begin
                  nxt_st.work = st.work + `DBA_AW'(1);
               end
            end
         end
      endcase

      // Sticky events: a new event beats a clear in the same cycle
      nxt_st.status = (st.status & ~clrBits) | {vStart, readyEvt};
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         st         <= '0;
         st.done    <= 1'b1;
         st.format  <= `DBA_FMT_RESET;
         st.control <= `DBA_CTL_RESET;
         st.blank   <= 1'b1;
      end else begin
         st <= nxt_st;
      end
   end

   assign bufferChipSelect  = (st.seq == SEQ_XFER) | (st.seq == SEQ_FILL);
   assign latchDriveStrobe  = bufferChipSelect & st.phase & st.doWrite;
   assign latchLoadStrobe   = (st.seq == SEQ_XFER) & st.phase & ~st.doWrite;
   assign ramAddr           = bufferChipSelect ? st.work : st.dispAddr;
   assign ramDataOut        = st.latch;
   assign ramDataOe         = latchDriveStrobe;
   assign hsync             = st.hsync;
   assign vsync             = st.vsync;
   assign compositeBlanking = st.blank;
   assign cursorOut         = st.cursorOut;
   assign lineAddr          = st.lineAddr;
   assign oddField          = st.field;
   assign link.latchQ          = st.latch;
   assign link.commandDoneFlag = st.done;
   assign link.readyIrq = |(st.status & {st.control[`DBA_CTL_MASKVBL],
                                         st.control[`DBA_CTL_MASKRDY]});
endmodule : dba_device
`default_nettype wire

//--- rtl/dba_host.sv
`timescale 1ns/1ps
`default_nettype none
module dba_host (
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   dba_link_if.host         link
);
   import dba_pkg::*;

   dba_hst_t st;
   dba_hst_t nxt_st;
   logic     idle;

   assign idle = (st.state == H_IDLE) & ~st.passPending;

   always_comb begin
      nxt_st = st;
      link.regWr      = 1'b0;
      link.regAddr    = `DBA_REG_CURSOR;
      link.regWdata   = '0;
      link.latchWr    = (st.state == H_LATCH);
      link.latchWdata = st.data;

      // Data phase of a bus write; orders while busy are dropped
      if (st.apValid && st.apWrite) begin
         unique case (st.apIdx)
            `DBA_H_ADDRA: nxt_st.addrA = hwdata[`DBA_AW-1:0];
            `DBA_H_ADDRB: nxt_st.addrB = hwdata[`DBA_AW-1:0];
            `DBA_H_DATA:  nxt_st.data  = hwdata[`DBA_DW-1:0];
            `DBA_H_ORDER: begin
               if (idle && hwdata[1:0] != 2'h3) begin
                  nxt_st.op    = hwdata[1:0];
                  nxt_st.wr    = hwdata[`DBA_CMD_WRITE] | (hwdata[1:0] == `DBA_OP_FILL);
                  nxt_st.incr  = hwdata[`DBA_CMD_INCR];
                  nxt_st.state = nxt_st.wr ? H_LATCH : H_ADDR1;
               end
            end
            `DBA_H_PASS: begin
               if (idle) begin
                  nxt_st.passAddr    = hwdata[18:16];
                  nxt_st.passData    = hwdata[15:0];
                  nxt_st.passPending = 1'b1;
               end
            end
            default: ;
         endcase
      end

      // Address phase: capture and prepare read data
      nxt_st.apValid = hsel & htrans[1] & hready;
      if (hsel && htrans[1] && hready) begin
         nxt_st.apWrite = hwrite;
         nxt_st.apIdx   = haddr[7:2];
         nxt_st.hrdata  = '0;
         if (!hwrite) begin
            unique case (haddr[7:2])
               `DBA_H_ADDRA: nxt_st.hrdata = 32'(st.addrA);
               `DBA_H_ADDRB: nxt_st.hrdata = 32'(st.addrB);
               `DBA_H_DATA:  nxt_st.hrdata = 32'(st.rdData);
               `DBA_H_ORDER: nxt_st.hrdata = {29'h0, link.readyIrq,
                                              link.commandDoneFlag, ~idle};
               default: ;
            endcase
         end
      end

      if (st.passPending) begin
         link.regWr         = 1'b1;
         link.regAddr       = st.passAddr;
         link.regWdata      = st.passData;
         nxt_st.passPending = 1'b0;
      end else begin
         unique case (st.state)
            H_IDLE: ;
            H_LATCH: nxt_st.state = H_ADDR1;
            H_ADDR1: begin
               link.regWr    = 1'b1;
               link.regAddr  = (st.op == `DBA_OP_POINTER) ?
                               `DBA_REG_POINTER : `DBA_REG_CURSOR;
               link.regWdata = `DBA_RW'(st.addrA);
               nxt_st.state  = (st.op == `DBA_OP_FILL) ? H_ADDR2 : H_CHECK;
            end
            H_ADDR2: begin
               link.regWr    = 1'b1;
               link.regAddr  = `DBA_REG_POINTER;
               link.regWdata = `DBA_RW'(st.addrB);
               nxt_st.state  = H_CHECK;
            end
            H_CHECK: begin
               if (link.commandDoneFlag) begin
                  nxt_st.state = H_CMD;
               end
            end
            H_CMD: begin
               link.regWr    = 1'b1;
               link.regAddr  = `DBA_REG_COMMAND;
               link.regWdata = {12'h0, st.incr, st.wr, st.op};
               nxt_st.state  = st.wr ? H_IDLE : H_SETTLE;
            end
            H_SETTLE: nxt_st.state = H_WAITRD;
            H_WAITRD: begin
               if (link.commandDoneFlag) begin
                  nxt_st.rdData = link.latchQ;
                  nxt_st.state  = H_IDLE;
               end
            end
         endcase
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= nxt_st;
      end
   end

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = st.hrdata;
endmodule : dba_host
`default_nettype wire

//--- rtl/dba_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface dba_link_if;
   import dba_pkg::*;
   logic       regWr;
   logic [2:0] regAddr;
   dba_reg_t   regWdata;
   logic       latchWr;
   dba_data_t  latchWdata;
   dba_data_t  latchQ;
   logic       commandDoneFlag;
   logic       readyIrq;
   modport device (input regWr, regAddr, regWdata, latchWr, latchWdata,
                   output latchQ, commandDoneFlag, readyIrq);
   modport host (output regWr, regAddr, regWdata, latchWr, latchWdata,
                 input latchQ, commandDoneFlag, readyIrq);
endinterface : dba_link_if
`default_nettype wire

//--- rtl/dba_params.svh
`ifndef DBA_PARAMS_SVH
`define DBA_PARAMS_SVH
// How it works
// - Generate raster timing, interlace selectable
// - Software sets format, cursor, blink, height
// - Events raise interrupt and show in status
// - Independent buffer configuration implemented here
// - Chip select and latch strobes move data
// - Device drives RAM address: cursor or pointer
// - Transfers happen only while display blanked
// - Pointer, cursor-with-increment and block fill commands
// - Ready interrupt when a command finishes
// - Command in active window waits for flyback; a fill starts at once
// - Command in vertical flyback runs at once; a read or write in the frame's last cycle waits
// - Host loads latch before write or fill
// - Host loads address, checks done, then commands
// - Write clears done, copies latch, sets done
// - Read clears done, fills latch, sets done
// - Host reads latch only after done
// - Host sets start cursor, end pointer before fill
// - Fill writes latch from cursor through pointer
// - Fill blanks screen until next vertical retrace
// - Fill writes one location per two characters
`define DBA_AW 14
`define DBA_DW 8
`define DBA_RW 16
`define DBA_REG_CURSOR 3'h0
`define DBA_REG_POINTER 3'h1
`define DBA_REG_COMMAND 3'h2
`define DBA_REG_CONTROL 3'h3
`define DBA_REG_FORMAT 3'h4
`define DBA_REG_STATUS 3'h5
`define DBA_OP_POINTER 2'h0
`define DBA_OP_CURSOR 2'h1
`define DBA_OP_FILL 2'h2
`define DBA_CMD_WRITE 2
`define DBA_CMD_INCR 3
`define DBA_CTL_INTERLACE 0
`define DBA_CTL_BLOCKCUR 1
`define DBA_CTL_BLINKFAST 2
`define DBA_CTL_DOUBLEH 3
`define DBA_CTL_BLANK 4
`define DBA_CTL_MASKRDY 5
`define DBA_CTL_MASKVBL 6
`define DBA_CTL_RESET 16'h0000
`define DBA_FMT_RESET 16'hc4d0
`define DBA_ST_READY 0
`define DBA_ST_VBLANK 1
`define DBA_HBLANK_CHARS 20
`define DBA_VBLANK_ROWS 2
`define DBA_HSYNC_START 4
`define DBA_HSYNC_END 12
`define DBA_VSYNC_LINES 3
`define DBA_H_ADDRA 6'h00
`define DBA_H_ADDRB 6'h01
`define DBA_H_DATA 6'h02
`define DBA_H_ORDER 6'h03
`define DBA_H_PASS 6'h04
`endif

//--- rtl/dba_pkg.sv
`include "dba_params.svh"
package dba_pkg;
   typedef logic [`DBA_AW-1:0] dba_addr_t;
   typedef logic [`DBA_DW-1:0] dba_data_t;
   typedef logic [`DBA_RW-1:0] dba_reg_t;
   typedef enum logic [1:0] {SEQ_IDLE, SEQ_WAIT, SEQ_XFER, SEQ_FILL} dba_seq_t;
   typedef enum logic [2:0] {
      H_IDLE, H_LATCH, H_ADDR1, H_ADDR2, H_CHECK, H_CMD, H_SETTLE, H_WAITRD
   } dba_hst_state_t;
   typedef struct packed {
      dba_seq_t  seq;
      logic      phase;
      logic      doWrite;
      logic      doIncr;
      logic      useCursor;
      dba_addr_t cursor;
      dba_addr_t pointer;
      dba_addr_t work;
      dba_data_t latch;
      dba_reg_t  control;
      dba_reg_t  format;
      logic [1:0] status;
      logic      done;
      logic      fillBlank;
      logic      field;
      logic [5:0] frame;
      dba_addr_t dispAddr;
      logic [3:0] lineAddr;
      logic      hsync;
      logic      vsync;
      logic      blank;
      logic      cursorOut;
   } dba_dev_t;
   typedef struct packed {
      dba_hst_state_t state;
      logic [1:0] op;
      logic      wr;
      logic      incr;
      dba_addr_t addrA;
      dba_addr_t addrB;
      dba_data_t data;
      dba_data_t rdData;
      logic [2:0] passAddr;
      dba_reg_t  passData;
      logic      passPending;
      logic      apValid;
      logic      apWrite;
      logic [5:0] apIdx;
      logic [31:0] hrdata;
   } dba_hst_t;
endpackage : dba_pkg

//--- rtl/dba_span_counter.sv
`timescale 1ns/1ps
`default_nettype none
module dba_span_counter #(
   parameter int W = 8
) (
   input  wire logic         mclk,
   input  wire logic         rst,
   input  wire logic         step,
   input  wire logic [W-1:0] limit,
   output logic      [W-1:0] count,
   output logic              wrap
);
   import dba_pkg::*;
   typedef struct packed {
      logic [W-1:0] count;
   } dba_span_t;
   dba_span_t st;
   dba_span_t nxt_st;

   // A limit lowered under the count still wraps at the next step
   always_comb begin
      nxt_st = st;
      wrap = step & (st.count >= limit);
      if (step) begin
         nxt_st.count = wrap ? '0 : st.count + W'(1);
      end
   end

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= nxt_st;
      end
   end

   assign count = st.count;
endmodule : dba_span_counter
`default_nettype wire

//--- test/dba_link_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "dba_params.svh"
module dba_link_props (
   input wire logic                mclk,
   input wire logic                rst,
   input wire logic                regWr,
   input wire logic [2:0]          regAddr,
   input wire dba_pkg::dba_reg_t   regWdata,
   input wire logic                latchWr,
   input wire dba_pkg::dba_data_t  latchWdata,
   input wire dba_pkg::dba_data_t  latchQ,
   input wire logic                commandDoneFlag,
   input wire logic                readyIrq
);
   import dba_pkg::*;
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   dba_reg_t ctlCopy_ff;
   logic     cmdTake;

   // A command is only accepted while idle and with a legal opcode
   assign cmdTake = regWr && regAddr == `DBA_REG_COMMAND && commandDoneFlag
                    && regWdata[1:0] != 2'h3;

   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ctlCopy_ff <= 16'h0000;
      end else if (regWr && regAddr == `DBA_REG_CONTROL) begin
         ctlCopy_ff <= regWdata;
      end
   end

   chk_reset_done: assert property ($fell(rst) |-> commandDoneFlag)
      else $error("done flag low after reset");
   chk_take_clears: assert property (cmdTake |=> !commandDoneFlag)
      else $error("done flag not cleared on command");
   chk_done_bounded: assert property (cmdTake |-> ##[2:1000] commandDoneFlag)
      else $error("command never completed");
   chk_fall_cause: assert property ($fell(commandDoneFlag) |-> $past(cmdTake))
      else $error("done flag fell without a command");
   chk_blank_fast: assert property (cmdTake && ctlCopy_ff[`DBA_CTL_BLANK]
      && regWdata[1:0] != `DBA_OP_FILL |-> ##[2:3] commandDoneFlag)
      else $error("blanked command did not run at once");
   chk_ready_irq: assert property ($rose(commandDoneFlag)
      && ctlCopy_ff[`DBA_CTL_MASKRDY] |-> readyIrq)
      else $error("no ready interrupt on completion");
   chk_irq_masked: assert property (readyIrq
      |-> ctlCopy_ff[`DBA_CTL_MASKRDY] || ctlCopy_ff[`DBA_CTL_MASKVBL])
      else $error("interrupt while all sources masked");
   chk_latch_load: assert property (latchWr && commandDoneFlag
      |=> latchQ == $past(latchWdata))
      else $error("latch did not take host data");
   chk_latch_hold: assert property (commandDoneFlag && !latchWr |=> $stable(latchQ))
      else $error("latch changed while idle");

   cov_fill: cover property (cmdTake && regWdata[1:0] == `DBA_OP_FILL);
   cov_read: cover property (cmdTake && !regWdata[`DBA_CMD_WRITE]);
   cov_irq: cover property ($rose(readyIrq));
endmodule : dba_link_props
`default_nettype wire

//--- test/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "dba_params.svh"
`define CHECK(got, exp) begin comparisons++; if ((got) !== (exp)) begin n_fail++; \
   $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module tb;
   import dba_pkg::*;
   logic        mclk, rst, hsel, hwrite, hready, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0]  htrans, op;
   logic [2:0]  hsize;
   logic        bufferChipSelect, latchLoadStrobe, latchDriveStrobe, ramDataOe, compositeBlanking;
   logic [7:0]  idleCnt;
   logic        hsync, hsPrev;
   dba_addr_t   ramAddr, a;
   dba_data_t   ramDataOut, ramDataIn, d;
   dba_data_t   mem [0:16383];
   int          n_fail, comparisons, busyRun, lastBusy, i, k, len, hsLen;

   dba_link_if link();
   dba_host dba_host_inst (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .link(link));
   dba_device dba_device_inst (.mclk(mclk), .rst(rst), .link(link),
      .bufferChipSelect(bufferChipSelect), .latchLoadStrobe(latchLoadStrobe),
      .latchDriveStrobe(latchDriveStrobe), .ramAddr(ramAddr), .ramDataOut(ramDataOut),
      .ramDataOe(ramDataOe), .ramDataIn(ramDataIn), .hsync(hsync), .vsync(),
      .compositeBlanking(compositeBlanking), .cursorOut(), .lineAddr(), .oddField());
   dba_link_props dba_link_props_inst (.mclk(mclk), .rst(rst), .regWr(link.regWr),
      .regAddr(link.regAddr), .regWdata(link.regWdata), .latchWr(link.latchWr),
      .latchWdata(link.latchWdata), .latchQ(link.latchQ),
      .commandDoneFlag(link.commandDoneFlag), .readyIrq(link.readyIrq));

   assign hready = hreadyout;
   // Unselected RAM shows a changing pattern, never the last value
   assign ramDataIn = bufferChipSelect ? mem[ramAddr] : ~idleCnt;

   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end

   always @(posedge mclk) begin
      idleCnt <= idleCnt + 8'h01;
      if (bufferChipSelect && latchDriveStrobe) mem[ramAddr] <= ramDataOut;
      if (latchDriveStrobe || latchLoadStrobe) `CHECK(compositeBlanking, 1'b1)
      busyRun <= link.commandDoneFlag ? 0 : busyRun + 1;
      if (link.commandDoneFlag && busyRun != 0) lastBusy <= busyRun;
      // Every horizontal sync pulse has the fixed width
      hsPrev <= hsync;
      hsLen  <= hsync ? hsLen + 1 : 0;
      if (hsPrev && !hsync) `CHECK(hsLen, `DBA_HSYNC_END - `DBA_HSYNC_START)
   end

   task stop_test;
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : stop_test

   task wait_ready;
      for (int j = 0; j < 50; j++) begin
         @(posedge mclk);
         if (hready === 1'b1) return;
      end
      n_fail++;
      stop_test();
   endtask : wait_ready

   task ahb(input logic w, input logic [31:0] adr, input logic [31:0] dat);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= adr;
      hwrite <= w;
      hsize <= 3'h2;
      wait_ready();
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= dat;
      wait_ready();
      rd = hrdata;
   endtask : ahb

   task pass(input logic [2:0] r, input logic [15:0] v);
      ahb(1'b1, 32'h10, {13'h0, r, v});
   endtask : pass

   // Poll the order status until done is set and the host is idle
   task wait_idle;
      for (int j = 0; j < 400; j++) begin
         ahb(1'b0, 32'h0c, 32'h0);
         if (j > 0 && rd[1:0] === 2'b10) return;
      end
      n_fail++;
      stop_test();
   endtask : wait_idle

   task job(input logic [1:0] o, input logic w, input logic inc, input dba_addr_t sa,
            input dba_addr_t ea, input dba_data_t v);
      ahb(1'b1, 32'h00, {18'h0, sa});
      ahb(1'b1, 32'h04, {18'h0, ea});
      ahb(1'b1, 32'h08, {24'h0, v});
      ahb(1'b1, 32'h0c, {28'h0, inc, w, o});
      wait_idle();
   endtask : job

   initial begin
      repeat (90000) @(posedge mclk);
      n_fail++;
      stop_test();
   end

   initial begin
      {rst, hsel, haddr, htrans, hwrite, hsize, hwdata} = {1'b1, 71'h0};
      {idleCnt, n_fail, comparisons, busyRun, lastBusy} = '0;
      void'($urandom(79));
      repeat (20) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      `CHECK(link.commandDoneFlag, 1'b1)
      ahb(1'b0, 32'h0c, 32'h0);
      `CHECK(rd[1:0], 2'b10)
      ahb(1'b1, 32'h20, 32'hffff_ffff);
      ahb(1'b0, 32'h20, 32'h0);
      `CHECK(rd, 32'h0000_0000)
      `CHECK(hresp, 1'b0)
      pass(`DBA_REG_FORMAT, 16'h2090);
      pass(`DBA_REG_CONTROL, 16'h0020);
      for (i = 0; i < 6; i++) begin
         op = i[0] ? `DBA_OP_CURSOR : `DBA_OP_POINTER;
         a = dba_addr_t'($urandom);
         d = dba_data_t'($urandom);
         job(op, 1'b1, 1'b0, a, 14'h0, d);
         `CHECK(mem[a], d)
         `CHECK(link.readyIrq, 1'b1)
         pass(`DBA_REG_STATUS, 16'h0001);
         ahb(1'b0, 32'h0c, 32'h0);
         `CHECK(link.readyIrq, 1'b0)
         job(op, 1'b0, 1'b0, a, 14'h0, 8'h00);
         ahb(1'b0, 32'h08, 32'h0);
         `CHECK(rd[7:0], d)
      end
      pass(`DBA_REG_CONTROL, 16'h0030);
      a = dba_addr_t'($urandom);
      d = dba_data_t'($urandom);
      job(`DBA_OP_CURSOR, 1'b1, 1'b1, a, 14'h0, d);
      `CHECK(lastBusy >= 2 && lastBusy <= 3, 1'b1)
      pass(`DBA_REG_COMMAND, 16'h000d);
      wait_idle();
      `CHECK(mem[a], d)
      `CHECK(mem[a + 14'h1], d)
      pass(`DBA_REG_CONTROL, 16'h0020);
      for (i = 0; i < 3; i++) begin
         len = $urandom_range(3, 12);
         a = dba_addr_t'($urandom_range(0, 16000));
         d = dba_data_t'($urandom);
         job(`DBA_OP_FILL, 1'b1, 1'b0, a, a + dba_addr_t'(len - 1), d);
         `CHECK(compositeBlanking, 1'b1)
         `CHECK(lastBusy >= 2 * len && lastBusy <= 2 * len + 4, 1'b1)
         for (k = 0; k < len; k++) `CHECK(mem[a + dba_addr_t'(k)], d)
      end
      stop_test();
   end
endmodule : tb
`default_nettype wire
